// [design/dpfs_hist_mem.sv]
// Small register file that keeps the fault history entries.
// Assumes one writer and one reader in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module dpfs_hist_mem #(
    parameter int W = 77,
    parameter int DEPTH = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write side
    input wire logic wr_en,
    input wire logic [1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    // Read side
    input wire logic [1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    logic [W-1:0] mem [DEPTH];
    initial
    begin
        if (DEPTH < 1 || DEPTH > 4)
            $error("dpfs_hist_mem depth must be 1 to 4");
    end
    // Entries are cleared at reset so an unwritten slot reads as no fault.
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_entry
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    mem[g] <= '0;
                else if (wr_en && wr_addr == 2'(g))
                    mem[g] <= wr_data;
            end
        end
    endgenerate
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= '0;
        else if (32'(rd_addr) < DEPTH)
            rd_data <= mem[rd_addr];
        else
            rd_data <= '0;
    end
endmodule
`default_nettype wire

// [design/dpfs_pkg.sv]
// Constants shared by the drive protection fault supervisor.
// Assumes all analog quantities arrive already digitised in the units named.
package dpfs_pkg;
    // Fault bit positions in the latched fault vector.
    localparam int FLT_N = 15;
    localparam int IDX_PHASE_OC = 0;
    localparam int IDX_GROUND_OC = 1;
    localparam int IDX_MOTOR_OT = 2;
    localparam int IDX_PTC_TRIP = 3;
    localparam int IDX_LINK_UV = 4;
    localparam int IDX_LINK_OV = 5;
    localparam int IDX_MODULE_OT = 6;
    localparam int IDX_MODULE_COMM = 7;
    localparam int IDX_SELFTUNE = 8;
    localparam int IDX_PANEL = 9;
    localparam int IDX_AUTODIAG = 10;
    localparam int IDX_FAN = 11;
    localparam int IDX_CPU = 12;
    localparam int IDX_VERSION = 13;
    localparam int IDX_PULSE_FB = 14;
    // Fault numbers, listed from the highest index down to index 0.
    localparam logic [FLT_N-1:0][9:0] FAULT_CODES = {
        10'h0b6, 10'h09e, 10'h050, 10'h0b3, 10'h054,
        10'h2bc, 10'h021, 10'h01f, 10'h033, 10'h016,
        10'h015, 10'h04f, 10'h04e, 10'h04a, 10'h046};
    localparam logic [9:0] ALARM_MODULE_OT = 10'h032;
    localparam logic [9:0] ALARM_PANEL = 10'h2bc;
    // Fault mask bit positions.
    localparam int MASK_GROUND_OC = 0;
    localparam int MASK_MOTOR_OT = 2;
    localparam int MASK_PTC_TRIP = 3;
    localparam int MASK_FAN = 5;
    localparam int MASK_PANEL = 7;
    // Control configuration bit positions.
    localparam int CFG_DERATE_OFF = 0;
    localparam int CFG_DEADTIME_ON = 1;
    // Thermistor limits, millivolts on the analog input.
    localparam logic [13:0] PTC_SHORT_MV = 14'h238c;
    localparam logic [13:0] PTC_OPEN_MV = 14'h0514;
    localparam logic [7:0] AIN_FUNC_PTC = 8'h04;
    localparam logic [7:0] DIN_FUNC_PTC = 8'h1d;
    localparam int DIN_FREQ_INPUT = 1;
    // Derated switching frequency in Hz.
    localparam logic [15:0] DERATED_FREQ_HZ = 16'h07d0;
    // Link voltage limits in volts per supply class.
    localparam logic [1:0] SUPPLY_LOW = 2'h0;
    localparam logic [1:0] SUPPLY_MID = 2'h1;
    localparam logic [10:0] UV_LOW = 11'h0c8;
    localparam logic [10:0] UV_MID = 11'h168;
    localparam logic [10:0] UV_HIGH = 11'h1f4;
    localparam logic [10:0] OV_LOW = 11'h19a;
    localparam logic [10:0] OV_MID = 11'h32a;
    localparam logic [10:0] OV_HIGH = 11'h3e8;
    // Mode and selection codes.
    localparam logic [3:0] SELFTUNE_VECTOR = 4'h1;
    localparam logic [3:0] DEFAULTS_A = 4'h5;
    localparam logic [3:0] DEFAULTS_B = 4'h6;
    localparam logic [3:0] PANEL_IF_REMOTE = 4'h1;
    localparam logic signed [7:0] FAN_ENABLE_C = 8'sh32;
    // Fault history.
    localparam int HIST_DEPTH = 3;
    localparam int HIST_W = 77;
    localparam logic [1:0] HIST_LAST_ADDR = 2'h2;
    localparam logic [7:0] DERATE_MARGIN_C = 8'h05;
endpackage

// [design/dpfs_top.sv]
// Fault and alarm supervisor for a motor inverter.
// Assumes all inputs are synchronous to clk and already digitised.
`timescale 1ns/1ns
`default_nettype none
module dpfs_top #(
    parameter int AIN_COUNT = 3,
    parameter int DIN_COUNT = 8,
    parameter logic [7:0] DERATE_MARGIN = dpfs_pkg::DERATE_MARGIN_C
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Analog thermistor inputs
    input wire logic [AIN_COUNT-1:0][13:0] ain_mv,
    input wire logic [AIN_COUNT-1:0][7:0] ain_function,
    input wire logic [AIN_COUNT-1:0] ain_current_mode,
    // Digital thermistor inputs, high when the sensor reads open
    input wire logic [DIN_COUNT-1:0][7:0] din_function,
    input wire logic [DIN_COUNT-1:0] din_ptc_open,
    input wire logic motor_ptc_trip,
    // Power module temperature and switching frequency
    input wire logic signed [7:0] module_temperature,
    input wire logic signed [7:0] module_alarm_level,
    input wire logic signed [7:0] module_fault_level,
    input wire logic [15:0] switching_frequency_setting,
    input wire logic [15:0] control_configuration,
    // Current and link voltage
    input wire logic phase_overcurrent,
    input wire logic ground_overcurrent,
    input wire logic [1:0] supply_class,
    input wire logic [10:0] link_voltage,
    // Plug-in module, self-tuning and version
    input wire logic module_present,
    input wire logic module_comm_ok,
    input wire logic selftune_done,
    input wire logic [3:0] selftune_mode,
    input wire logic [15:0] stator_resistance,
    input wire logic [15:0] stator_resistance_limit,
    input wire logic stator_resistance_written,
    input wire logic version_valid,
    input wire logic [15:0] nv_version,
    input wire logic [15:0] module_version,
    // Remote panel
    input wire logic [3:0] panel_interface_select,
    input wire logic panel_link_ok,
    input wire logic [8:0] command_source_panel,
    // Fan, pulse feedback, defaults and processor
    input wire logic signed [7:0] internal_temperature,
    input wire logic [15:0] fan_speed,
    input wire logic [15:0] fan_rated_speed,
    input wire logic pulse_feedback_defect,
    input wire logic load_defaults_request,
    input wire logic [3:0] load_defaults_select,
    input wire logic hw_ident_ok,
    input wire logic exec_monitor_error,
    // Fault handling and logged quantities
    input wire logic [15:0] fault_mask,
    input wire logic fault_reset,
    input wire logic [15:0] output_current,
    input wire logic [15:0] output_frequency,
    input wire logic [15:0] logical_status_word,
    input wire logic [1:0] hist_sel,
    // Outputs
    output logic pwm_enable,
    output logic [15:0] switching_frequency,
    output logic load_defaults_start,
    output logic [dpfs_pkg::FLT_N-1:0] fault_active,
    output logic [15:0] present_alarm_number,
    output logic [15:0] present_fault_number,
    output var logic [dpfs_pkg::HIST_W-1:0] hist_entry
);
    import dpfs_pkg::*;

    initial
    begin
        if (AIN_COUNT < 1 || DIN_COUNT < 2 || DERATE_MARGIN > 8'h40)
            $error("dpfs_top parameters out of range");
    end

    // Reset release through two flip-flops.
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Thermistor evaluation per input.
    logic [AIN_COUNT-1:0] ain_trip;
    logic [DIN_COUNT-1:0] din_trip;
    genvar g;
    generate
        for (g = 0; g < AIN_COUNT; g++)
        begin : g_ain
            assign ain_trip[g] = ain_function[g] == AIN_FUNC_PTC
                && ain_current_mode[g]
                && (ain_mv[g] > PTC_SHORT_MV || ain_mv[g] < PTC_OPEN_MV);
        end
        for (g = 0; g < DIN_COUNT; g++)
        begin : g_din
            // A short looks like normal on a digital input.
            if (g == DIN_FREQ_INPUT)
            begin : g_freq
                assign din_trip[g] = 1'b0;
            end
            else
            begin : g_ptc
                assign din_trip[g] = din_function[g] == DIN_FUNC_PTC
                    && din_ptc_open[g];
            end
        end
    endgenerate

    // Module temperature checks and derating.
    wire module_alarm = module_temperature >= module_alarm_level;
    wire module_hot = module_temperature >= module_fault_level;
    wire signed [8:0] derate_level =
        9'(module_alarm_level) - 9'(signed'({1'b0, DERATE_MARGIN}));
    wire derate_on = 9'(module_temperature) >= derate_level
        && !control_configuration[CFG_DERATE_OFF];
    wire [15:0] next_switching_frequency =
        derate_on ? DERATED_FREQ_HZ : switching_frequency_setting;

    // Link voltage limits by supply class.
    wire [10:0] uv_level = supply_class == SUPPLY_LOW ? UV_LOW :
        supply_class == SUPPLY_MID ? UV_MID : UV_HIGH;
    wire [10:0] ov_level = supply_class == SUPPLY_LOW ? OV_LOW :
        supply_class == SUPPLY_MID ? OV_MID : OV_HIGH;

    // Remote panel and fan conditions.
    wire panel_selected = panel_interface_select == PANEL_IF_REMOTE;
    wire panel_broken = panel_selected && !panel_link_ok
        && !fault_mask[MASK_PANEL];
    wire [17:0] fan_meas3 = 18'(fan_speed) * 18'h3;
    wire [17:0] fan_rated2 = 18'(fan_rated_speed) * 18'h2;
    wire rs_high = stator_resistance > stator_resistance_limit;
    wire defaults_sel = load_defaults_select == DEFAULTS_A
        || load_defaults_select == DEFAULTS_B;
    logic version_checked;

    // Raw fault conditions.
    logic [FLT_N-1:0] cond;
    assign cond[IDX_PHASE_OC] = phase_overcurrent;
    assign cond[IDX_GROUND_OC] = ground_overcurrent;
    assign cond[IDX_MOTOR_OT] = |ain_trip || |din_trip;
    assign cond[IDX_PTC_TRIP] = motor_ptc_trip;
    assign cond[IDX_LINK_UV] = link_voltage < uv_level;
    assign cond[IDX_LINK_OV] = link_voltage > ov_level;
    assign cond[IDX_MODULE_OT] = module_hot;
    assign cond[IDX_MODULE_COMM] = module_present && !module_comm_ok;
    assign cond[IDX_SELFTUNE] = rs_high && (stator_resistance_written
        || (selftune_done && selftune_mode == SELFTUNE_VECTOR));
    assign cond[IDX_PANEL] = panel_broken && |command_source_panel;
    assign cond[IDX_AUTODIAG] = load_defaults_request && defaults_sel
        && !hw_ident_ok;
    assign cond[IDX_FAN] = internal_temperature > FAN_ENABLE_C
        && fan_meas3 < fan_rated2;
    assign cond[IDX_CPU] = exec_monitor_error;
    assign cond[IDX_VERSION] = version_valid && !version_checked
        && nv_version != module_version;
    assign cond[IDX_PULSE_FB] = control_configuration[CFG_DEADTIME_ON]
        && pulse_feedback_defect;

    // Masked faults are never latched.
    logic [FLT_N-1:0] mask_vec;
    always_comb
    begin
        mask_vec = '0;
        mask_vec[IDX_GROUND_OC] = fault_mask[MASK_GROUND_OC];
        mask_vec[IDX_MOTOR_OT] = fault_mask[MASK_MOTOR_OT];
        mask_vec[IDX_PTC_TRIP] = fault_mask[MASK_PTC_TRIP];
        mask_vec[IDX_FAN] = fault_mask[MASK_FAN];
        mask_vec[IDX_PANEL] = fault_mask[MASK_PANEL];
    end

    // A new fault in the reset cycle wins over the reset.
    wire [FLT_N-1:0] set_vec = cond & ~mask_vec;
    wire [FLT_N-1:0] new_set = set_vec & ~fault_active;
    wire [FLT_N-1:0] next_fault_active =
        (fault_reset ? '0 : fault_active) | set_vec;

    // Lowest index has priority for the reported number.
    function automatic logic [9:0] pick_code(input logic [FLT_N-1:0] v);
        logic [9:0] c;
        c = 10'h000;
        for (int i = FLT_N - 1; i >= 0; i--)
        begin
            if (v[i])
                c = FAULT_CODES[i];
        end
        return c;
    endfunction

    wire [9:0] next_fault_code = pick_code(next_fault_active);
    wire [9:0] new_code = pick_code(new_set);
    wire [9:0] next_alarm_code = module_alarm ? ALARM_MODULE_OT :
        panel_broken ? ALARM_PANEL : 10'h000;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_active <= '0;
            pwm_enable <= 1'b0;
            switching_frequency <= 16'h0000;
            load_defaults_start <= 1'b0;
            present_alarm_number <= 16'h0000;
            present_fault_number <= 16'h0000;
            version_checked <= 1'b0;
        end
        else
        begin
            fault_active <= next_fault_active;
            pwm_enable <= ~|next_fault_active;
            switching_frequency <= next_switching_frequency;
            load_defaults_start <= load_defaults_request && defaults_sel
                && hw_ident_ok;
            present_alarm_number <= {6'h00, next_alarm_code};
            present_fault_number <= {6'h00, next_fault_code};
            version_checked <= version_checked || version_valid;
        end
    end

    // Fault history ring of three entries.
    logic [1:0] hist_ptr;
    wire hist_wr = |new_set;
    wire [HIST_W-1:0] hist_wdata = {new_code, output_current, link_voltage,
        output_frequency, module_temperature, logical_status_word};
    wire [1:0] back = hist_sel > HIST_LAST_ADDR ? HIST_LAST_ADDR : hist_sel;
    wire [2:0] rd_sum = 3'(hist_ptr) + 3'(HIST_DEPTH) - 3'(back) - 3'h1;
    wire [1:0] hist_rd_addr = rd_sum >= 3'(HIST_DEPTH) ?
        2'(rd_sum - 3'(HIST_DEPTH)) : rd_sum[1:0];
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hist_ptr <= 2'h0;
        else if (hist_wr)
            hist_ptr <= hist_ptr == HIST_LAST_ADDR ? 2'h0 : hist_ptr + 2'h1;
    end

    dpfs_hist_mem #(
        .W(HIST_W),
        .DEPTH(HIST_DEPTH)
    ) u_hist (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(hist_wr),
        .wr_addr(hist_ptr),
        .wr_data(hist_wdata),
        .rd_addr(hist_rd_addr),
        .rd_data(hist_entry)
    );

    // Checks.
    a_ain_ptc_trip: assert property (@(posedge clk) disable iff (!rst_n)
        |ain_trip && !fault_mask[MASK_MOTOR_OT]
        |=> fault_active[IDX_MOTOR_OT] && !pwm_enable)
        else $error("analog thermistor trip not latched");
    a_din_freq_skip: assert property (@(posedge clk) disable iff (!rst_n)
        din_trip[DIN_FREQ_INPUT] == 1'b0)
        else $error("frequency input used as thermistor");
    a_derate_freq: assert property (@(posedge clk) disable iff (!rst_n)
        derate_on |=> switching_frequency == DERATED_FREQ_HZ)
        else $error("switching frequency not derated");
    a_derate_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        control_configuration[CFG_DERATE_OFF]
        |=> switching_frequency == $past(switching_frequency_setting))
        else $error("derating active while disabled");
    a_pwm_cut_oc: assert property (@(posedge clk) disable iff (!rst_n)
        phase_overcurrent |=> !pwm_enable && present_fault_number == 16'h0046)
        else $error("overcurrent did not cut pwm");
    a_undervolt_low: assert property (@(posedge clk) disable iff (!rst_n)
        supply_class == SUPPLY_LOW && link_voltage < 11'h0c8
        |=> fault_active[IDX_LINK_UV])
        else $error("undervoltage not raised");
    a_overvolt_mid: assert property (@(posedge clk) disable iff (!rst_n)
        supply_class == SUPPLY_MID && link_voltage > 11'h32a
        |=> fault_active[IDX_LINK_OV])
        else $error("overvoltage not raised");
    a_panel_no_src: assert property (@(posedge clk) disable iff (!rst_n)
        command_source_panel == 9'h000 && !fault_active[IDX_PANEL]
        && !fault_reset |=> !fault_active[IDX_PANEL])
        else $error("panel fault without panel source");
    a_mask_ground: assert property (@(posedge clk) disable iff (!rst_n)
        fault_mask[MASK_GROUND_OC] && !fault_active[IDX_GROUND_OC]
        |=> !fault_active[IDX_GROUND_OC])
        else $error("masked ground fault reported");
    a_fault_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        fault_active[IDX_CPU] && !fault_reset |=> fault_active[IDX_CPU])
        else $error("fault dropped without reset");
    a_version_once: assert property (@(posedge clk) disable iff (!rst_n)
        version_checked && !fault_active[IDX_VERSION]
        |=> !fault_active[IDX_VERSION])
        else $error("version compared more than once");
    a_hist_advance: assert property (@(posedge clk) disable iff (!rst_n)
        hist_wr && hist_ptr == 2'h2 |=> hist_ptr == 2'h0)
        else $error("history pointer did not wrap");
endmodule
`default_nettype wire

// [verification/dpfs_plant.sv]
// Behavioural model of the power stage sensors and the remote panel link.
// Assumes the bench commands each value; answers land just after an edge.
`timescale 1ns/1ns
`default_nettype none
module dpfs_plant (
    // Clock
    input wire logic clk,
    // Commands from the bench
    input wire logic [10:0] cmd_link,
    input wire logic [1:0] cmd_oc,
    input wire logic cmd_panel_ok,
    // Sensor outputs seen by the supervisor
    output logic [10:0] link_voltage,
    output logic phase_overcurrent,
    output logic ground_overcurrent,
    output logic panel_link_ok
);
    // Sensors lag the command by one cycle, as a real filter would.
    always @(posedge clk)
    begin
        link_voltage <= #1 cmd_link;
        phase_overcurrent <= #1 cmd_oc[0];
        ground_overcurrent <= #1 cmd_oc[1];
        panel_link_ok <= #1 cmd_panel_ok;
    end
endmodule
`default_nettype wire

// [verification/tb_drive_protection_fault_supervisor.sv]
// Self-checking bench for the fault supervisor and its sensor model.
// Assumes the package constants; expectations are built from fixed limits.
`timescale 1ns/1ns
`default_nettype none
module tb_drive_protection_fault_supervisor;
    import dpfs_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0][13:0] ain_mv;
    logic [2:0][7:0] ain_function;
    logic [2:0] ain_current_mode;
    logic [7:0][7:0] din_function;
    logic [7:0] din_ptc_open;
    logic signed [7:0] module_temperature, internal_temperature;
    logic signed [7:0] alarm_lvl = 8'sh50;
    logic [15:0] switching_frequency_setting, control_configuration;
    logic [15:0] stator_resistance, fan_speed, fault_mask, output_current;
    logic [15:0] output_frequency, logical_status_word;
    logic [1:0] supply_class, cmd_oc;
    logic [10:0] link_voltage, cmd_link;
    logic [3:0] selftune_mode, panel_interface_select, load_defaults_select;
    logic [8:0] command_source_panel;
    logic motor_ptc_trip, phase_overcurrent, ground_overcurrent;
    logic panel_link_ok, cmd_panel_ok, module_present, module_comm_ok;
    logic selftune_done, stator_resistance_written, pulse_feedback_defect;
    logic load_defaults_request, hw_ident_ok, exec_monitor_error;
    logic fault_reset, pwm_enable, load_defaults_start;
    logic version_valid = 1'b1;
    logic [15:0] switching_frequency, present_alarm_number;
    logic [15:0] present_fault_number;
    logic [FLT_N-1:0] fault_active;
    logic [HIST_W-1:0] hist_entry;
    logic [79:0] exp_q[$];
    int kind_q[$];
    int num_errors = 0;
    int checks_done = 0;
    logic [15:0] lfsr = 16'h0017;
    logic [13:0] mv_tab[4] = '{14'h238d, 14'h238c, 14'h0513, 14'h0514};
    logic [10:0] uv_tab[3] = '{11'h0c8, 11'h168, 11'h1f4};
    logic [10:0] ov_tab[3] = '{11'h19a, 11'h32a, 11'h3e8};
    logic [10:0] ok_tab[4] = '{11'h12c, 11'h190, 11'h258, 11'h258};
    event probe;

    dpfs_plant u_dpfs_plant (.clk, .cmd_link, .cmd_oc, .cmd_panel_ok,
        .link_voltage, .phase_overcurrent, .ground_overcurrent,
        .panel_link_ok);
    dpfs_top u_dpfs_top (.clk, .nrst, .ain_mv, .ain_function,
        .ain_current_mode, .din_function, .din_ptc_open, .motor_ptc_trip,
        .module_temperature, .module_alarm_level(alarm_lvl),
        .module_fault_level(alarm_lvl + 8'sh0a),
        .switching_frequency_setting,
        .control_configuration, .phase_overcurrent, .ground_overcurrent,
        .supply_class, .link_voltage, .module_present, .module_comm_ok,
        .selftune_done, .selftune_mode, .stator_resistance,
        .stator_resistance_limit(16'h0100), .stator_resistance_written,
        .version_valid, .nv_version(16'h0001), .module_version(16'h0002),
        .panel_interface_select, .panel_link_ok, .command_source_panel,
        .internal_temperature, .fan_speed, .fan_rated_speed(16'h0064),
        .pulse_feedback_defect, .load_defaults_request,
        .load_defaults_select, .hw_ident_ok, .exec_monitor_error,
        .fault_mask, .fault_reset, .output_current, .output_frequency,
        .logical_status_word, .hist_sel(2'h0), .pwm_enable,
        .switching_frequency, .load_defaults_start, .fault_active,
        .present_alarm_number, .present_fault_number, .hist_entry);

    always #2 clk = ~clk;

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic settle;
        tick;
        tick;
    endtask

    task automatic expect_val(input int k, input logic [79:0] v);
        exp_q.push_back(v);
        kind_q.push_back(k);
        ->probe;
    endtask

    task automatic chk_flt(input int idx, input logic on);
        expect_val(0, on ? {49'h0, 15'h1 << idx, 6'h0, FAULT_CODES[idx]}
            : 80'h0);
    endtask

    function automatic logic [79:0] observed(input int k);
        case (k)
            0: return {49'h0, fault_active, present_fault_number};
            1: return {64'h0, present_alarm_number};
            2: return {64'h0, switching_frequency};
            3: return {78'h0, load_defaults_start, pwm_enable};
            default: return {3'h0, hist_entry};
        endcase
    endfunction

    // Drains every note, since several can be posted in one time step.
    always @(probe)
    begin
        while (exp_q.size() > 0)
        begin
            checks_done++;
            if (observed(kind_q[0]) !== exp_q[0])
            begin
                num_errors++;
                $display("ERROR t=%0t exp=%h got=%h", $time, exp_q[0],
                    observed(kind_q[0]));
            end
            void'(exp_q.pop_front());
            void'(kind_q.pop_front());
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic quiet;
        lfsr = lfsr_next(lfsr);
        ain_mv = {3{14'h0514 + {4'h0, lfsr[9:0]}}};
        ain_function = '0;
        ain_current_mode = '1;
        din_function = '0;
        din_ptc_open = '0;
        motor_ptc_trip = 1'b0;
        module_temperature = 8'sh28;
        internal_temperature = 8'sh14;
        switching_frequency_setting = 16'h1388;
        control_configuration = 16'h0000;
        stator_resistance = 16'h0200;
        fan_speed = 16'h0064;
        fault_mask = 16'h0000;
        output_current = lfsr;
        output_frequency = ~lfsr;
        logical_status_word = lfsr ^ 16'h5a5a;
        cmd_oc = 2'h0;
        selftune_mode = 4'h0;
        panel_interface_select = 4'h0;
        load_defaults_select = 4'h0;
        command_source_panel = 9'h000;
        cmd_panel_ok = 1'b0;
        module_present = 1'b0;
        module_comm_ok = 1'b0;
        selftune_done = 1'b0;
        stator_resistance_written = 1'b0;
        pulse_feedback_defect = 1'b0;
        load_defaults_request = 1'b0;
        hw_ident_ok = 1'b1;
        exec_monitor_error = 1'b0;
        fault_reset = 1'b0;
    endtask

    // Sources go quiet before the reset pulse, else the set would win.
    task automatic clear;
        quiet;
        cmd_link = ok_tab[supply_class];
        settle;
        fault_reset = 1'b1;
        tick;
        fault_reset = 1'b0;
        settle;
        chk_flt(0, 1'b0);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #40000;
        num_errors++;
        give_verdict;
    end

    initial
    begin
        quiet;
        supply_class = 2'h0;
        cmd_link = 11'h12c;
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (4) tick;
        chk_flt(IDX_VERSION, 1'b1);
        clear;
        for (int i = 0; i < 4; i++)
        begin
            ain_function[2] = AIN_FUNC_PTC;
            ain_mv[2] = mv_tab[i];
            settle;
            chk_flt(IDX_MOTOR_OT, i[0] == 1'b0);
            clear;
        end
        ain_function = {8'h03, 8'h04, 8'h04};
        ain_current_mode = 3'h4;
        ain_mv = '0;
        din_function[1] = DIN_FUNC_PTC;
        din_function[0] = 8'h1c;
        din_ptc_open = '1;
        settle;
        chk_flt(IDX_MOTOR_OT, 1'b0);
        din_function[7] = DIN_FUNC_PTC;
        settle;
        chk_flt(IDX_MOTOR_OT, 1'b1);
        clear;
        cmd_oc = 2'h1;
        settle;
        chk_flt(IDX_PHASE_OC, 1'b1);
        expect_val(3, 80'h0);
        tick;
        expect_val(4, {3'h0, 10'h046, output_current, link_voltage,
            output_frequency, module_temperature, logical_status_word});
        cmd_oc = 2'h0;
        settle;
        chk_flt(IDX_PHASE_OC, 1'b1);
        clear;
        expect_val(3, 80'h1);
        cmd_oc = 2'h2;
        settle;
        chk_flt(IDX_GROUND_OC, 1'b1);
        clear;
        fault_mask = 16'h0009;
        cmd_oc = 2'h2;
        motor_ptc_trip = 1'b1;
        settle;
        chk_flt(0, 1'b0);
        clear;
        for (int c = 0; c < 3; c++)
        begin
            cmd_link = ok_tab[c];
            settle;
            supply_class = c[1:0];
            clear;
            cmd_link = uv_tab[c];
            settle;
            chk_flt(IDX_LINK_UV, 1'b0);
            cmd_link = uv_tab[c] - 11'h001;
            settle;
            chk_flt(IDX_LINK_UV, 1'b1);
            clear;
            cmd_link = ov_tab[c];
            settle;
            chk_flt(IDX_LINK_OV, 1'b0);
            cmd_link = ov_tab[c] + 11'h001;
            settle;
            chk_flt(IDX_LINK_OV, 1'b1);
            clear;
        end
        module_present = 1'b1;
        settle;
        chk_flt(IDX_MODULE_COMM, 1'b1);
        clear;
        selftune_mode = 4'h2;
        selftune_done = 1'b1;
        tick;
        selftune_done = 1'b0;
        settle;
        chk_flt(IDX_SELFTUNE, 1'b0);
        selftune_mode = SELFTUNE_VECTOR;
        selftune_done = 1'b1;
        tick;
        selftune_done = 1'b0;
        settle;
        chk_flt(IDX_SELFTUNE, 1'b1);
        clear;
        panel_interface_select = PANEL_IF_REMOTE;
        settle;
        expect_val(1, 80'h2bc);
        chk_flt(IDX_PANEL, 1'b0);
        command_source_panel = 9'h004;
        settle;
        chk_flt(IDX_PANEL, 1'b1);
        cmd_panel_ok = 1'b1;
        settle;
        expect_val(1, 80'h0);
        clear;
        internal_temperature = 8'sh33;
        fan_speed = 16'h0043;
        settle;
        chk_flt(IDX_FAN, 1'b0);
        internal_temperature = 8'sh32;
        fan_speed = 16'h0000;
        settle;
        chk_flt(IDX_FAN, 1'b0);
        internal_temperature = 8'sh33;
        fan_speed = 16'h0042;
        settle;
        chk_flt(IDX_FAN, 1'b1);
        clear;
        pulse_feedback_defect = 1'b1;
        settle;
        chk_flt(IDX_PULSE_FB, 1'b0);
        control_configuration = 16'h0002;
        settle;
        chk_flt(IDX_PULSE_FB, 1'b1);
        clear;
        for (int k = 5; k < 7; k++)
        begin
            load_defaults_select = k[3:0];
            load_defaults_request = 1'b1;
            tick;
            expect_val(3, 80'h3);
            hw_ident_ok = 1'b0;
            load_defaults_request = 1'b1;
            tick;
            load_defaults_request = 1'b0;
            settle;
            chk_flt(IDX_AUTODIAG, 1'b1);
            clear;
        end
        exec_monitor_error = 1'b1;
        settle;
        chk_flt(IDX_CPU, 1'b1);
        clear;
        module_temperature = 8'sh4e;
        settle;
        expect_val(2, 80'h7d0);
        control_configuration = 16'h0001;
        settle;
        expect_val(2, 80'h1388);
        module_temperature = 8'sh55;
        settle;
        expect_val(1, 80'h032);
        chk_flt(0, 1'b0);
        alarm_lvl = 8'sh4b;
        settle;
        chk_flt(IDX_MODULE_OT, 1'b1);
        settle;
        give_verdict;
    end
endmodule
`default_nettype wire
